// File: pkg/tbl_pkg.sv
/*
  Shared constants for the tile reset, clock and boot loader:
  register offsets, field layouts, reset values, timing and loader states.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package tbl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int INT_RST_US = 15;
  localparam int INT_RST_CYC = INT_RST_US * CLK_MHZ;
  localparam int INT_RST_W = 12;

  localparam int APB_AW = 12;
  localparam logic [11:0] OFF_PLL = 12'h000;
  localparam logic [11:0] OFF_RATIO = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_SIZE = 12'h00c;
  localparam logic [11:0] OFF_CRC = 12'h010;
  localparam logic [11:0] OFF_CLKDIV = 12'h014;
  localparam logic [11:0] OFF_PORTCLK = 12'h028;
  localparam logic [11:0] OFF_RAMADDR = 12'h02c;
  localparam logic [11:0] OFF_RAMDATA = 12'h030;

  localparam int PLL_R_LSB = 0;
  localparam int PLL_R_W = 6;
  localparam int PLL_F_LSB = 6;
  localparam int PLL_F_W = 12;
  localparam int PLL_OD_LSB = 18;
  localparam int PLL_OD_W = 3;
  localparam logic [5:0] PLL_R_INIT = 6'h00;
  localparam logic [11:0] PLL_F_INIT = 12'h03f;
  localparam logic [2:0] PLL_OD_INIT = 3'h1;
  localparam int RATIO_DEN_LSB = 16;
  localparam logic [10:0] RATIO_FB_DIV = 11'h002;

  localparam int NUM_CLK_BLK = 6;
  localparam int CLKDIV_W = 8;
  localparam int PORT_SEL_W = 3;
  localparam logic [2:0] PORT_SEL_INIT = 3'h0;

  localparam int SEC_BOOT_BIT = 5;
  localparam logic BOOT_SRC_FLASH = 1'b0;
  localparam logic BOOT_SRC_OTP = 1'b1;
  localparam logic [23:0] OTP_START = 24'h000000;
  localparam logic [23:0] FLASH_START = 24'h000000;
  localparam logic [31:0] EXEC_ADDR = 32'h00000000;

  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;

  localparam int STAT_SRC_BIT = 7;
  localparam int STAT_PD_BIT = 8;

  typedef enum logic [6:0] {
    ST_HOLD = 7'h01,
    ST_IRST = 7'h02,
    ST_SIZE = 7'h04,
    ST_PROG = 7'h08,
    ST_CHK = 7'h10,
    ST_RUN = 7'h20,
    ST_ERR = 7'h40
  } tbl_state_t;
endpackage

// File: pkg/tbl_ram_if.sv
/*
  Word-wide RAM port bundle between the boot loader and its program RAM.
  Assumes one write port driven by the loader and one read port for software.
*/
`timescale 1ns/1ps
interface tbl_ram_if #(parameter int AW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [31:0] wdata;
  logic [AW-1:0] raddr;
  logic [31:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: src/tbl_ram.sv
/*
  Program RAM of the tile: one write port, one registered read port.
  Assumes a single clock; read data follows the read address by one cycle.
*/
`timescale 1ns/1ps
module tbl_ram #(
  parameter int DEPTH = 65536,
  parameter int AW = 16
) (
  input wire logic sys_clk,
  tbl_ram_if.mem ram
);
  if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_chk
    $error("tbl_ram: depth does not fit the address width");
  end

  logic [31:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (ram.we) begin
      mem[ram.waddr] <= ram.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    ram.rdata <= mem[ram.raddr];
  end
endmodule

// File: src/tbl_crc.sv
/*
  Byte-serial reflected CRC-32 engine; output is the inverted residue.
  Assumes bytes arrive one per enable, least significant bit processed first.
*/
`timescale 1ns/1ps
module tbl_crc (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  logic [31:0] residue;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ tbl_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (srst || init) begin
      residue <= tbl_pkg::CRC_PRESET;
    end else if (en) begin
      residue <= crc_byte(residue, data);
    end
  end

  assign crc = ~residue;
endmodule

// File: src/tbl_boot_top.sv
/*
  Tile reset, PLL start-up settings, clock blocks and boot image loader,
  with an APB register slave.
  Assumes ext_rst_n and the boot byte port are synchronous to sys_clk, and
  sec_reg already holds the security word read from OTP.
*/
// Contract
// - while ext_rst_n is low the block stays in reset, no boot activity
// - pull-downs on all GPIO are enabled while held in reset
// - after release, internal reset then boot starts 15 to 150 us later
// - start-up PLL settings: output divider 1, feedback 63, reference 0
// - tile clock = osc times (F+1)/2 over (R+1) over (OD+1)
// - the PLL configuration register write changes OD, F and R
// - clock block 0 is the 100 MHz reference; others programmable
// - on reset every port is attached to clock block 0
// - security bit 5 set boots from OTP, clear boots from flash
// - image starts with 32-bit word count, then four bytes per word
// - checksum word follows program; 0x0D15AB1E skips the check
// - size and checksum words are least significant byte first
// - program written to RAM from lowest address, run from there
// - checksum covers size word and program bytes, not itself
// - reflected poly 0xEDB88320, preset all ones, residue inverted
// - secure boot starts reading at OTP address 0
`timescale 1ns/1ps
module tbl_boot_top #(
  parameter int RAM_WORDS = 65536,
  parameter int RAM_AW = 16,
  parameter int NUM_PORTS = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_rst_n,
  input wire logic [31:0] sec_reg,
  output logic gpio_pd_en,
  output logic boot_req,
  output logic boot_src,
  output logic [23:0] boot_addr,
  input wire logic boot_ack,
  input wire logic [7:0] boot_byte,
  output logic exec_start,
  output logic [31:0] exec_addr,
  output logic boot_err,
  output logic [2:0] pll_output_divider,
  output logic [11:0] pll_f,
  output logic [5:0] pll_r,
  output logic [tbl_pkg::NUM_CLK_BLK-1:0] clk_blk_en,
  output logic [NUM_PORTS*tbl_pkg::PORT_SEL_W-1:0] port_clk_sel
);
  if (RAM_WORDS < 2 || RAM_WORDS > (1 << RAM_AW) || NUM_PORTS < 1 || NUM_PORTS > 10)
  begin : g_chk
    $error("tbl_boot_top: unsupported RAM or port count");
  end

  tbl_pkg::tbl_state_t state;
  logic [tbl_pkg::INT_RST_W-1:0] rst_cnt;
  logic [1:0] byte_idx;
  logic [31:0] asm_word;
  logic [31:0] asm_next;
  logic [31:0] size_word;
  logic [RAM_AW:0] word_cnt;
  logic fire;
  logic [31:0] crc_val;
  logic [RAM_AW-1:0] ram_rd_addr;
  logic [31:0] ratio_word;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [tbl_pkg::CLKDIV_W-1:0] div_reg [tbl_pkg::NUM_CLK_BLK];
  logic [31:0] next_prdata;

  tbl_ram_if #(.AW(RAM_AW)) ram_bus ();

  assign fire = boot_req & boot_ack;
  assign asm_next = {boot_byte, asm_word[31:8]};
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;

  // main loader sequence
  always_ff @(posedge sys_clk) begin
    if (srst || !ext_rst_n) begin
      state <= tbl_pkg::ST_HOLD;
    end else begin
      case (state)
        tbl_pkg::ST_HOLD: begin
          state <= tbl_pkg::ST_IRST;
        end
        tbl_pkg::ST_IRST: begin
          if (rst_cnt == tbl_pkg::INT_RST_W'(tbl_pkg::INT_RST_CYC - 1)) begin
            state <= tbl_pkg::ST_SIZE;
          end
        end
        tbl_pkg::ST_SIZE: begin
          if (fire && byte_idx == 2'h3) begin
            if (asm_next == 32'h00000000) begin
              state <= tbl_pkg::ST_CHK;
            end else if (asm_next > 32'(RAM_WORDS)) begin
              state <= tbl_pkg::ST_ERR;
            end else begin
              state <= tbl_pkg::ST_PROG;
            end
          end
        end
        tbl_pkg::ST_PROG: begin
          if (fire && byte_idx == 2'h3 && 32'(word_cnt + 1'b1) == size_word) begin
            state <= tbl_pkg::ST_CHK;
          end
        end
        tbl_pkg::ST_CHK: begin
          if (fire && byte_idx == 2'h3) begin
            if (asm_next == tbl_pkg::CRC_SKIP || asm_next == crc_val) begin
              state <= tbl_pkg::ST_RUN;
            end else begin
              state <= tbl_pkg::ST_ERR;
            end
          end
        end
        tbl_pkg::ST_RUN: begin
          state <= tbl_pkg::ST_RUN;
        end
        tbl_pkg::ST_ERR: begin
          state <= tbl_pkg::ST_ERR;
        end
        default: begin
          state <= tbl_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // internal reset delay counter
  always_ff @(posedge sys_clk) begin
    if (srst || state != tbl_pkg::ST_IRST) begin
      rst_cnt <= '0;
    end else begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gpio_pd_en <= 1'b1;
    end else begin
      gpio_pd_en <= !ext_rst_n || state == tbl_pkg::ST_HOLD;
    end
  end

  // boot source and fetch address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      boot_src <= tbl_pkg::BOOT_SRC_FLASH;
      boot_addr <= tbl_pkg::FLASH_START;
    end else if (state == tbl_pkg::ST_IRST) begin
      if (sec_reg[tbl_pkg::SEC_BOOT_BIT]) begin
        boot_src <= tbl_pkg::BOOT_SRC_OTP;
        boot_addr <= tbl_pkg::OTP_START;
      end else begin
        boot_src <= tbl_pkg::BOOT_SRC_FLASH;
        boot_addr <= tbl_pkg::FLASH_START;
      end
    end else if (fire) begin
      boot_addr <= boot_addr + 1'b1;
    end
  end

  assign boot_req = state == tbl_pkg::ST_SIZE || state == tbl_pkg::ST_PROG ||
                    state == tbl_pkg::ST_CHK;

  // little-endian word assembly
  always_ff @(posedge sys_clk) begin
    if (srst || state == tbl_pkg::ST_IRST) begin
      byte_idx <= 2'h0;
      asm_word <= '0;
    end else if (fire) begin
      byte_idx <= byte_idx + 1'b1;
      asm_word <= asm_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || state == tbl_pkg::ST_IRST) begin
      size_word <= '0;
    end else if (fire && byte_idx == 2'h3 && state == tbl_pkg::ST_SIZE) begin
      size_word <= asm_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || state == tbl_pkg::ST_IRST) begin
      word_cnt <= '0;
    end else if (ram_bus.we) begin
      word_cnt <= word_cnt + 1'b1;
    end
  end

  assign ram_bus.we = fire && byte_idx == 2'h3 && state == tbl_pkg::ST_PROG;
  assign ram_bus.waddr = word_cnt[RAM_AW-1:0];
  assign ram_bus.wdata = asm_next;
  assign ram_bus.raddr = ram_rd_addr;

  tbl_ram #(.DEPTH(RAM_WORDS), .AW(RAM_AW)) u_ram (
    .sys_clk(sys_clk),
    .ram(ram_bus.mem)
  );

  tbl_crc u_crc (
    .sys_clk(sys_clk),
    .srst(srst),
    .init(state == tbl_pkg::ST_IRST),
    .en(fire && (state == tbl_pkg::ST_SIZE || state == tbl_pkg::ST_PROG)),
    .data(boot_byte),
    .crc(crc_val)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exec_start <= 1'b0;
      exec_addr <= tbl_pkg::EXEC_ADDR;
      boot_err <= 1'b0;
    end else begin
      exec_start <= state == tbl_pkg::ST_CHK && fire && byte_idx == 2'h3 &&
                    (asm_next == tbl_pkg::CRC_SKIP || asm_next == crc_val);
      exec_addr <= tbl_pkg::EXEC_ADDR;
      boot_err <= state == tbl_pkg::ST_ERR;
    end
  end

  // pll configuration, defaults reloaded while held in reset
  always_ff @(posedge sys_clk) begin
    if (srst || !ext_rst_n || state == tbl_pkg::ST_HOLD) begin
      pll_output_divider <= tbl_pkg::PLL_OD_INIT;
      pll_f <= tbl_pkg::PLL_F_INIT;
      pll_r <= tbl_pkg::PLL_R_INIT;
    end else if (apb_wr && paddr == tbl_pkg::OFF_PLL) begin
      pll_output_divider <= pwdata[tbl_pkg::PLL_OD_LSB +: tbl_pkg::PLL_OD_W];
      pll_f <= pwdata[tbl_pkg::PLL_F_LSB +: tbl_pkg::PLL_F_W];
      pll_r <= pwdata[tbl_pkg::PLL_R_LSB +: tbl_pkg::PLL_R_W];
    end
  end

  // ratio as numerator (F+1) and denominator 2(R+1)(OD+1)
  always_comb begin
    ratio_word = '0;
    ratio_word[12:0] = 13'(pll_f) + 13'h0001;
    ratio_word[tbl_pkg::RATIO_DEN_LSB +: 11] =
      11'(tbl_pkg::RATIO_FB_DIV * (11'(pll_r) + 11'h001) * (11'(pll_output_divider) + 11'h001));
  end

  // clock blocks: block 0 is the reference clock itself
  assign clk_blk_en[0] = 1'b1;
  assign div_reg[0] = '0;

  for (genvar g = 1; g < tbl_pkg::NUM_CLK_BLK; g++) begin : g_clkblk
    logic [tbl_pkg::CLKDIV_W-1:0] cnt;
    logic [tbl_pkg::CLKDIV_W-1:0] div;
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        div <= '0;
      end else if (apb_wr && paddr == tbl_pkg::OFF_CLKDIV + 12'(4 * (g - 1))) begin
        div <= pwdata[tbl_pkg::CLKDIV_W-1:0];
      end
    end
    always_ff @(posedge sys_clk) begin
      if (srst || cnt >= div) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
    assign clk_blk_en[g] = cnt >= div;
    assign div_reg[g] = div;
  end

  // port clock selection
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge sys_clk) begin
      if (srst || !ext_rst_n || state == tbl_pkg::ST_HOLD) begin
        port_clk_sel[p*tbl_pkg::PORT_SEL_W +: tbl_pkg::PORT_SEL_W] <=
          tbl_pkg::PORT_SEL_INIT;
      end else if (apb_wr && paddr == tbl_pkg::OFF_PORTCLK) begin
        port_clk_sel[p*tbl_pkg::PORT_SEL_W +: tbl_pkg::PORT_SEL_W] <=
          pwdata[p*tbl_pkg::PORT_SEL_W +: tbl_pkg::PORT_SEL_W];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ram_rd_addr <= '0;
    end else if (apb_wr && paddr == tbl_pkg::OFF_RAMADDR) begin
      ram_rd_addr <= pwdata[RAM_AW-1:0];
    end
  end

  // apb read mux and decode
  always_comb begin
    next_prdata = '0;
    addr_ok = 1'b1;
    case (paddr)
      tbl_pkg::OFF_PLL: begin
        next_prdata[tbl_pkg::PLL_OD_LSB +: tbl_pkg::PLL_OD_W] = pll_output_divider;
        next_prdata[tbl_pkg::PLL_F_LSB +: tbl_pkg::PLL_F_W] = pll_f;
        next_prdata[tbl_pkg::PLL_R_LSB +: tbl_pkg::PLL_R_W] = pll_r;
      end
      tbl_pkg::OFF_RATIO: begin
        next_prdata = ratio_word;
      end
      tbl_pkg::OFF_STATUS: begin
        next_prdata[6:0] = state;
        next_prdata[tbl_pkg::STAT_SRC_BIT] = boot_src;
        next_prdata[tbl_pkg::STAT_PD_BIT] = gpio_pd_en;
      end
      tbl_pkg::OFF_SIZE: begin
        next_prdata = size_word;
      end
      tbl_pkg::OFF_CRC: begin
        next_prdata = crc_val;
      end
      tbl_pkg::OFF_PORTCLK: begin
        next_prdata[NUM_PORTS*tbl_pkg::PORT_SEL_W-1:0] = port_clk_sel;
      end
      tbl_pkg::OFF_RAMADDR: begin
        next_prdata[RAM_AW-1:0] = ram_rd_addr;
      end
      tbl_pkg::OFF_RAMDATA: begin
        next_prdata = ram_bus.rdata;
      end
      default: begin
        addr_ok = 1'b0;
        for (int k = 1; k < tbl_pkg::NUM_CLK_BLK; k++) begin
          if (paddr == tbl_pkg::OFF_CLKDIV + 12'(4 * (k - 1))) begin
            addr_ok = 1'b1;
            next_prdata[tbl_pkg::CLKDIV_W-1:0] = div_reg[k];
          end
        end
      end
    endcase
  end

  // read data registered in the setup cycle, stable through access
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= '0;
    end else if (apb_rd && !penable) begin
      prdata <= next_prdata;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
endmodule

// File: bench/tbl_boot_chk.sv
/*
  Port checker for tbl_boot_top: reset hold, boot delay, byte fetch, start and error.
  Assumes it is bound to tbl_boot_top and sees one clock domain.
*/
`timescale 1ns/1ps
module tbl_boot_chk #(parameter int NUM_PORTS = 4) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ext_rst_n,
  input wire logic [31:0] sec_reg,
  input wire logic gpio_pd_en,
  input wire logic boot_req,
  input wire logic boot_src,
  input wire logic [23:0] boot_addr,
  input wire logic boot_ack,
  input wire logic exec_start,
  input wire logic [31:0] exec_addr,
  input wire logic boot_err,
  input wire logic [2:0] pll_output_divider,
  input wire logic [11:0] pll_f,
  input wire logic [5:0] pll_r,
  input wire logic [tbl_pkg::NUM_CLK_BLK-1:0] clk_blk_en,
  input wire logic [NUM_PORTS*tbl_pkg::PORT_SEL_W-1:0] port_clk_sel
);
  logic [15:0] wait_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // idle cycles since the reset pin was released
  always_ff @(posedge sys_clk) begin
    if (srst || !ext_rst_n) wait_cnt <= 16'h0;
    else if (!boot_req && wait_cnt != 16'hffff) wait_cnt <= wait_cnt + 16'h1;
  end
  hold_quiet_a: assert property (!ext_rst_n |=> !boot_req && !exec_start)
    else $error("boot activity while reset pin low");
  pull_down_a: assert property (!ext_rst_n |=> gpio_pd_en)
    else $error("pull-downs off while in reset");
  pll_init_a: assert property (!ext_rst_n |=> pll_output_divider == 3'h1 &&
    pll_f == 12'h03f && pll_r == 6'h00)
    else $error("pll start-up settings wrong");
  port_init_a: assert property (!ext_rst_n |=> port_clk_sel == '0)
    else $error("port clock select not block 0");
  boot_delay_a: assert property ($rose(boot_req) |-> wait_cnt >= 16'h05dc &&
    wait_cnt <= 16'h3a98)
    else $error("boot start outside 15-150 us");
  first_addr_a: assert property ($rose(boot_req) |-> boot_addr == 24'h0)
    else $error("fetch does not start at 0");
  src_sel_a: assert property (boot_req |-> boot_src == sec_reg[tbl_pkg::SEC_BOOT_BIT])
    else $error("boot source differs from security bit");
  addr_step_a: assert property (boot_req && boot_ack && ext_rst_n |=>
    boot_addr == $past(boot_addr) + 24'h1)
    else $error("fetch address did not advance");
  exec_pulse_a: assert property (exec_start |=> !exec_start)
    else $error("start pulse longer than one cycle");
  exec_zero_a: assert property (exec_start |-> exec_addr == 32'h0 && !boot_err)
    else $error("start address not 0 or start with error");
  err_sticky_a: assert property (boot_err && ext_rst_n |=> boot_err)
    else $error("boot error dropped");
  ref_clk_a: assert property (clk_blk_en[0])
    else $error("reference clock block not running");
  cover property (exec_start && boot_src);
  cover property (exec_start && !boot_src);
  cover property ($rose(boot_err));
endmodule

// File: bench/tbl_boot_src_model.sv
/*
  Boot byte source: flash image (index 0) and OTP image (index 1).
  Assumes the bench fills mem before releasing reset; slow halves the byte rate.
*/
`timescale 1ns/1ps
module tbl_boot_src_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic boot_req,
  input wire logic boot_src,
  input wire logic [23:0] boot_addr,
  input wire logic slow,
  output logic boot_ack,
  output logic [7:0] boot_byte
);
  logic [7:0] mem [2][256];
  always_ff @(posedge sys_clk) begin
    if (srst) boot_ack <= 1'b0;
    else boot_ack <= boot_req && !(slow && boot_ack);
  end
  // image bytes in stored order; inverted garbage while not acknowledging
  assign boot_byte = boot_ack ? mem[boot_src][boot_addr[7:0]]
    : ~mem[boot_src][boot_addr[7:0]];
endmodule

// File: bench/tbl_boot_top_tb_top.sv
/*
  Testbench for tbl_boot_top: APB register access, three boots and a clock block.
  Assumes tbl_boot_src_model as byte source and tbl_boot_chk bound below.
*/
`timescale 1ns/1ps
module tbl_boot_top_tb_top;
  localparam int NP = 4;
  logic sys_clk = 1'b0;
  logic srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_rst_n = 1'b0;
  logic slow = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, sec_reg = 32'h0;
  logic [31:0] prdata, exec_addr, rd, exp_crc;
  logic pready, pslverr, gpio_pd_en, boot_req, boot_src, boot_ack, exec_start, boot_err, err;
  logic [23:0] boot_addr;
  logic [7:0] boot_byte;
  logic [2:0] pll_output_divider;
  logic [11:0] pll_f;
  logic [5:0] pll_r, clk_blk_en;
  logic [NP*3-1:0] port_clk_sel;
  logic [31:0] prog [16];
  int fail_count = 0, total_checks = 0, cyc = 0, n, res;
  always #5 sys_clk = ~sys_clk;
  tbl_boot_top #(.RAM_WORDS(64), .RAM_AW(6), .NUM_PORTS(NP)) u_dut (.sys_clk, .srst,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ext_rst_n,
    .sec_reg, .gpio_pd_en, .boot_req, .boot_src, .boot_addr, .boot_ack, .boot_byte,
    .exec_start, .exec_addr, .boot_err, .pll_output_divider, .pll_f, .pll_r, .clk_blk_en,
    .port_clk_sel);
  tbl_boot_src_model u_src (.sys_clk, .srst, .boot_req, .boot_src, .boot_addr, .slow,
    .boot_ack, .boot_byte);
  task test_done();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the cycle ceiling below ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic [31:0] crc8(input logic [31:0] c0, input logic [7:0] b);
    logic [31:0] c;
    c = c0 ^ {24'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return c;
  endfunction
  // image: size word, program, then good, skip or corrupted checksum
  task load(input int s, input int nw, input int mode);
    logic [31:0] c, w;
    c = 32'hffffffff;
    for (int i = 0; i <= nw + 1; i++) begin
      if (i == 0) w = nw;
      else if (i <= nw) w = 32'h5a00_0000 ^ (s << 16) ^ (i * 32'h0001_0307);
      else w = (mode == 1) ? tbl_pkg::CRC_SKIP : (mode == 0) ? ~c : ~c ^ 32'h1;
      if (i > 0 && i <= nw) prog[i-1] = w;
      for (int j = 0; j < 4; j++) begin
        u_src.mem[s][4*i+j] = w[8*j +: 8];
        if (i <= nw) c = crc8(c, w[8*j +: 8]);
      end
    end
    exp_crc = ~c;
  endtask
  task boot(input logic sec);
    @(posedge sys_clk);
    ext_rst_n <= 1'b0;
    sec_reg <= {26'h0, sec, 5'h0};
    repeat (20) @(posedge sys_clk); // supply settling shortened
    chk(gpio_pd_en, 32'h1);
    chk(boot_req, 32'h0);
    chk({pll_output_divider, pll_f, pll_r}, 32'h0004_0fc0);
    chk(port_clk_sel, 32'h0);
    ext_rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (boot_req !== 1'b1 && n < 20000);
    chk(n >= 1500 && n <= 15000, 32'h1);
    n = 0;
    res = 0;
    while (res == 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
      if (exec_start === 1'b1) res = 1;
      else if (boot_err === 1'b1) res = 2;
    end
    chk(boot_src, sec);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    apb(1'b0, tbl_pkg::OFF_PLL, 32'h0);
    chk(rd, 32'h0004_0fc0);
    apb(1'b0, tbl_pkg::OFF_RATIO, 32'h0);
    chk(rd, 32'h0004_0040);
    load(0, 5, 0);
    slow <= 1'b1;
    boot(1'b0);
    chk(res, 32'h1);
    apb(1'b0, tbl_pkg::OFF_SIZE, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, tbl_pkg::OFF_CRC, 32'h0);
    chk(rd, exp_crc);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, tbl_pkg::OFF_RAMADDR, i);
      repeat (2) @(posedge sys_clk);
      apb(1'b0, tbl_pkg::OFF_RAMDATA, 32'h0);
      chk(rd, prog[i]);
    end
    apb(1'b1, tbl_pkg::OFF_PLL, 32'h0000_18c1);
    #1;
    chk({pll_output_divider, pll_f, pll_r}, 32'h0000_18c1);
    apb(1'b0, tbl_pkg::OFF_RATIO, 32'h0);
    chk(rd, 32'h0004_0064);
    apb(1'b1, tbl_pkg::OFF_PORTCLK, 32'h0000_0fff);
    apb(1'b1, tbl_pkg::OFF_CLKDIV, 32'h3);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (clk_blk_en[1] === 1'b1) n++;
    end
    chk(n, 32'ha);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    load(1, 3, 1);
    slow <= 1'b0;
    boot(1'b1);
    chk(res, 32'h1);
    load(0, 2, 2);
    boot(1'b0);
    chk(res, 32'h2);
    test_done();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
endmodule
bind tbl_boot_top tbl_boot_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.sys_clk, .srst, .ext_rst_n,
  .sec_reg, .gpio_pd_en, .boot_req, .boot_src, .boot_addr, .boot_ack, .exec_start,
  .exec_addr, .boot_err, .pll_output_divider, .pll_f, .pll_r, .clk_blk_en, .port_clk_sel);
